// >>> hdl/clock_monitor_pkg.sv
// Purpose: Shared constants and carriers for the clock monitor interrupt unit.
// Assumes: Register port with byte-wide addresses and 32-bit data.
// Notes: Each monitor occupies a block of sixteen addresses.
package clock_monitor_pkg;
   localparam int NUM_MON = 3;
   localparam int CNT_W = 13;
   // Global register addresses.
   localparam logic [7:0] ADDR_INT_EN = 8'h00;
   localparam logic [7:0] ADDR_INT_STS = 8'h01;
   localparam logic [7:0] ADDR_SOFT_RST = 8'h02;
   localparam logic [7:0] ADDR_LOCK_SEL = 8'h03;
   // Per-monitor block base and offsets.
   localparam logic [7:0] ADDR_MON_BASE = 8'h10;
   localparam logic [7:0] ADDR_MON_STRIDE = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_EVENT = 8'h01;
   localparam logic [7:0] OFF_QUAL = 8'h02;
   localparam logic [7:0] OFF_WINDOW = 8'h03;
   localparam logic [7:0] OFF_THRESH = 8'h04;
   localparam logic [7:0] OFF_NOMINAL = 8'h05;
   // Field positions.
   localparam int INT_GLOBAL_BIT = 15;
   localparam int INT_SRC_W = 9;
   localparam int INT_EN_RW_MSB = 11;
   localparam int QUAL_GOOD_LSB = 4;
   localparam int WIN_DIV_LSB = 3;
   localparam int WIN_REF_DIS_BIT = 1;
   localparam int WIN_MASK_BIT = 0;
   localparam int THR_ACC_LSB = 16;
   localparam int STS_INVALID_BIT = 1;
   // Reset values and the value read from unmapped addresses.
   localparam logic [15:0] INT_EN_RESET = 16'h0000;
   localparam logic LOS_STS_RESET = 1'b1;
   localparam logic LOS_EVT_RESET = 1'b1;
   localparam logic INVALID_RESET = 1'b1;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   typedef struct packed {
      logic [3:0] goodTimes;
      logic [3:0] failTimes;
      logic [4:0] divRatio;
      logic refDisable;
      logic failMask;
      logic [CNT_W-1:0] accMargin;
      logic [CNT_W-1:0] rejMargin;
      logic [CNT_W-1:0] nominal;
   } los_cfg_t;

   typedef struct packed {
      logic digitalLoopStateEvent;
      logic digitalLoopHoldoverEvent;
      logic digitalLoopLockLossEvent;
      logic analogLoopLockLossEvent;
   } loop_events_t;
endpackage : clock_monitor_pkg

// >>> hdl/clock_monitor_interrupt_unit.sv
// Purpose: Interrupt aggregation with three loss-of-signal monitors.
// Assumes: Activity and loop events come from logic on sys_clk.
// Notes: Monitored clocks are pins, sampled through two flip-flops.
`timescale 1ns/1ns
`default_nettype none
module clock_monitor_interrupt_unit (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [31:0] regRdData,
   output logic regRdValid,
   input wire logic [clock_monitor_pkg::NUM_MON-1:0] monitorClock,
   input wire logic [1:0] activityDisqualify,
   input wire logic [1:0] activityEvent,
   input wire clock_monitor_pkg::loop_events_t loopEvents,
   input wire logic loopLockStatus,
   output logic lockStatusPin,
   output logic deviceIrq
);
   localparam int N = clock_monitor_pkg::NUM_MON;
   localparam int W = clock_monitor_pkg::CNT_W;

   // Address of register off inside the block of monitor m.
   function automatic logic [7:0] monAddr(input int m, input logic [7:0] off);
      monAddr = 8'(clock_monitor_pkg::ADDR_MON_BASE
         + 8'(m) * clock_monitor_pkg::ADDR_MON_STRIDE + off);
   endfunction : monAddr

   // Distance between a window count and the nominal count, never negative.
   function automatic logic [W-1:0] absDiff(input logic [W-1:0] a, input logic [W-1:0] b);
      absDiff = (a > b) ? W'(a - b) : W'(b - a);
   endfunction : absDiff

   // A programmed count of zero is used as a count of one.
   function automatic logic [3:0] atLeastOne(input logic [3:0] v);
      atLeastOne = (v == 4'h0) ? 4'h1 : v;
   endfunction : atLeastOne

   // Configuration, status and event state, one entry per monitor where indexed.
   logic [15:0] intEnable_reg;
   logic [N-1:0] softReset_reg;
   logic lockSel_reg;
   clock_monitor_pkg::los_cfg_t cfg_reg [N];
   logic [N-1:0] losSts_reg;
   logic [N-1:0] losEvt_reg;
   logic [N-1:0] refInvalid_reg;
   logic [31:0] regRdData_next;
   logic [15:0] intStatus;
   logic [clock_monitor_pkg::INT_SRC_W-1:0] srcStatus;
   logic globalStatus;

   // Global register write decodes; reads are decoded in the read mux below.
   wire wrIntEn = regWrEn && (regAddr == clock_monitor_pkg::ADDR_INT_EN);
   wire wrSoftRst = regWrEn && (regAddr == clock_monitor_pkg::ADDR_SOFT_RST);
   wire wrLockSel = regWrEn && (regAddr == clock_monitor_pkg::ADDR_LOCK_SEL);

   // Source order: activity inverted, activity true, crystal, inverted, true loss, loops.
   assign srcStatus = {activityEvent[1], activityEvent[0], losEvt_reg[2], losEvt_reg[1],
      losEvt_reg[0], loopEvents};
   assign globalStatus = |(srcStatus & intEnable_reg[clock_monitor_pkg::INT_SRC_W-1:0]);
   assign intStatus = {globalStatus, 6'h00, srcStatus};

   // Spare enable bits 11:9 are writable; bits 14:12 always read 0.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         intEnable_reg <= clock_monitor_pkg::INT_EN_RESET;
         softReset_reg <= '0;
         lockSel_reg <= 1'b0;
      end else begin
         if (wrIntEn) begin
            intEnable_reg <= {regWrData[clock_monitor_pkg::INT_GLOBAL_BIT], 3'h0,
               regWrData[clock_monitor_pkg::INT_EN_RW_MSB:0]};
         end
         if (wrSoftRst) begin
            softReset_reg <= regWrData[N-1:0];
         end
         if (wrLockSel) begin
            lockSel_reg <= regWrData[0];
         end
      end
   end

   // Both pin outputs are registered so they change one cycle after their cause.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         deviceIrq <= 1'b0;
         lockStatusPin <= 1'b0;
      end else begin
         deviceIrq <= intEnable_reg[clock_monitor_pkg::INT_GLOBAL_BIT] && globalStatus;
         lockStatusPin <= lockSel_reg
            ? (intEnable_reg[clock_monitor_pkg::INT_GLOBAL_BIT] && globalStatus)
            : loopLockStatus;
      end
   end

   // One monitor per clock: 0 true input, 1 inverted input, 2 crystal.
   genvar m;
   generate
      for (m = 0; m < N; m++) begin : g_mon
         logic [2:0] clkSync;
         logic started;
         logic [4:0] edgeCnt;
         logic [W-1:0] winCnt;
         logic [3:0] goodCnt;
         logic [3:0] failCnt;
         wire monReset = rst || softReset_reg[m];
         wire clkEdge = clkSync[1] && !clkSync[2];
         wire [4:0] divEff = (cfg_reg[m].divRatio <= 5'd1) ? 5'd1 : cfg_reg[m].divRatio;
         wire [4:0] edgeNext = 5'(edgeCnt + 5'd1);
         wire winEnd = clkEdge && started && (edgeNext >= divEff);
         wire [W-1:0] diff = absDiff(winCnt, cfg_reg[m].nominal);
         wire accepted = diff <= cfg_reg[m].accMargin;
         wire rejected = diff > cfg_reg[m].rejMargin;
         // A count already past nominal plus the reject margin can only end outside it,
         // so the window is rejected early and a stopped clock is still seen as lost.
         wire overrun = started && (winCnt > cfg_reg[m].nominal) && rejected;
         wire winDone = winEnd || overrun;
         wire [3:0] goodNext = 4'(goodCnt + 4'd1);
         wire [3:0] failNext = 4'(failCnt + 4'd1);
         wire [3:0] goodEff = atLeastOne(cfg_reg[m].goodTimes);
         wire [3:0] failEff = atLeastOne(cfg_reg[m].failTimes);
         wire evtClear = regWrEn && (regAddr == monAddr(m, clock_monitor_pkg::OFF_EVENT))
            && regWrData[0];
         wire wrQual = regWrEn && (regAddr == monAddr(m, clock_monitor_pkg::OFF_QUAL));
         wire wrWin = regWrEn && (regAddr == monAddr(m, clock_monitor_pkg::OFF_WINDOW));
         wire wrThr = regWrEn && (regAddr == monAddr(m, clock_monitor_pkg::OFF_THRESH));
         wire wrNom = regWrEn && (regAddr == monAddr(m, clock_monitor_pkg::OFF_NOMINAL));
         wire refDisabled = (m < 2) && cfg_reg[m].refDisable;
         wire actBad = (m < 2) ? activityDisqualify[m % 2] : 1'b0;

         // Two flops synchronise the pin; the third only serves the rising edge detect.
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               clkSync <= 3'b000;
            end else begin
               clkSync <= {clkSync[1:0], monitorClock[m]};
            end
         end

         // Configuration stays writable while the monitor is held in soft reset.
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               cfg_reg[m] <= '0;
            end else begin
               if (wrQual) begin
                  cfg_reg[m].goodTimes <= regWrData[clock_monitor_pkg::QUAL_GOOD_LSB +: 4];
                  cfg_reg[m].failTimes <= regWrData[3:0];
               end
               if (wrWin) begin
                  cfg_reg[m].divRatio <= regWrData[clock_monitor_pkg::WIN_DIV_LSB +: 5];
                  cfg_reg[m].refDisable <= regWrData[clock_monitor_pkg::WIN_REF_DIS_BIT];
                  cfg_reg[m].failMask <= regWrData[clock_monitor_pkg::WIN_MASK_BIT];
               end
               if (wrThr) begin
                  cfg_reg[m].accMargin <= regWrData[clock_monitor_pkg::THR_ACC_LSB +: W];
                  cfg_reg[m].rejMargin <= regWrData[W-1:0];
               end
               if (wrNom) begin
                  cfg_reg[m].nominal <= regWrData[W-1:0];
               end
            end
         end

         // Windows open on the first monitored edge after release from reset.
         always_ff @(posedge sys_clk) begin
            if (monReset) begin
               started <= 1'b0;
               edgeCnt <= '0;
               winCnt <= '0;
               goodCnt <= '0;
               failCnt <= '0;
               losSts_reg[m] <= clock_monitor_pkg::LOS_STS_RESET;
            end else begin
               if (clkEdge) begin
                  started <= 1'b1;
               end
               if (winDone || (clkEdge && !started)) begin
                  edgeCnt <= '0;
               end else if (clkEdge) begin
                  edgeCnt <= edgeNext;
               end
               if (winDone || !started) begin
                  winCnt <= '0;
               end else if (winCnt != {W{1'b1}}) begin
                  winCnt <= W'(winCnt + 1'b1);
               end
               if (cfg_reg[m].nominal == '0) begin
                  losSts_reg[m] <= 1'b1;
                  goodCnt <= '0;
                  failCnt <= '0;
               end else if (winDone && rejected) begin
                  goodCnt <= '0;
                  if (!losSts_reg[m]) begin
                     if (failNext >= failEff) begin
                        losSts_reg[m] <= 1'b1;
                        failCnt <= '0;
                     end else begin
                        failCnt <= failNext;
                     end
                  end
               end else if (winEnd && accepted && losSts_reg[m]) begin
                  if (goodNext >= goodEff) begin
                     losSts_reg[m] <= 1'b0;
                     goodCnt <= '0;
                     failCnt <= '0;
                  end else begin
                     goodCnt <= goodNext;
                  end
               end
            end
         end

         // Loss sets the event in every cycle, so a clear during loss has no effect.
         always_ff @(posedge sys_clk) begin
            if (monReset) begin
               losEvt_reg[m] <= clock_monitor_pkg::LOS_EVT_RESET;
            end else begin
               losEvt_reg[m] <= losSts_reg[m] || (losEvt_reg[m] && !evtClear);
            end
         end

         // The crystal monitor has no selection disable and no activity monitor.
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               refInvalid_reg[m] <= clock_monitor_pkg::INVALID_RESET;
            end else begin
               refInvalid_reg[m] <= refDisabled || actBad
                  || (losSts_reg[m] && !cfg_reg[m].failMask);
            end
         end
      end
   endgenerate

   // Read mux; unmapped addresses and reserved bits read as 0.
   always_comb begin
      regRdData_next = clock_monitor_pkg::READ_UNMAPPED;
      if (regAddr == clock_monitor_pkg::ADDR_INT_EN) begin
         regRdData_next = {16'h0000, intEnable_reg};
      end else if (regAddr == clock_monitor_pkg::ADDR_INT_STS) begin
         regRdData_next = {16'h0000, intStatus};
      end else if (regAddr == clock_monitor_pkg::ADDR_SOFT_RST) begin
         regRdData_next = {29'h0000_0000, softReset_reg};
      end else if (regAddr == clock_monitor_pkg::ADDR_LOCK_SEL) begin
         regRdData_next = {31'h0000_0000, lockSel_reg};
      end else begin
         for (int i = 0; i < N; i++) begin
            if (regAddr == monAddr(i, clock_monitor_pkg::OFF_STATUS)) begin
               regRdData_next = {30'h0000_0000, refInvalid_reg[i], losSts_reg[i]};
            end else if (regAddr == monAddr(i, clock_monitor_pkg::OFF_EVENT)) begin
               regRdData_next = {31'h0000_0000, losEvt_reg[i]};
            end else if (regAddr == monAddr(i, clock_monitor_pkg::OFF_QUAL)) begin
               regRdData_next = {24'h00_0000, cfg_reg[i].goodTimes, cfg_reg[i].failTimes};
            end else if (regAddr == monAddr(i, clock_monitor_pkg::OFF_WINDOW)) begin
               regRdData_next = {24'h00_0000, cfg_reg[i].divRatio, 1'b0,
                  cfg_reg[i].refDisable, cfg_reg[i].failMask};
            end else if (regAddr == monAddr(i, clock_monitor_pkg::OFF_THRESH)) begin
               regRdData_next = {3'h0, cfg_reg[i].accMargin, 3'h0, cfg_reg[i].rejMargin};
            end else if (regAddr == monAddr(i, clock_monitor_pkg::OFF_NOMINAL)) begin
               regRdData_next = {19'h0_0000, cfg_reg[i].nominal};
            end
         end
      end
   end

   // Read data is captured with the strobe and held until the next read.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         regRdData <= '0;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            regRdData <= regRdData_next;
         end
      end
   end
endmodule : clock_monitor_interrupt_unit
`default_nettype wire

// >>> tb/clock_monitor_interrupt_unit_asserts.sv
// Purpose: Port-level assertions for the clock monitor interrupt unit.
// Assumes: Enable and lock-select values are shadowed from register writes.
// Notes: Bound to every instance of the unit.
`timescale 1ns/1ns
`default_nettype none
module clock_monitor_interrupt_unit_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [31:0] regRdData,
   input wire logic regRdValid,
   input wire logic loopLockStatus,
   input wire logic lockStatusPin,
   input wire logic deviceIrq
);
   logic [15:0] enShadow_reg;
   logic lockSel_reg;
   wire logic enWrite = regWrEn && (regAddr == clock_monitor_pkg::ADDR_INT_EN);
   wire logic selWrite = regWrEn && (regAddr == clock_monitor_pkg::ADDR_LOCK_SEL);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         enShadow_reg <= 16'h0000;
         lockSel_reg <= 1'b0;
      end else begin
         if (enWrite) enShadow_reg <= regWrData[15:0] & 16'h8FFF;
         if (selWrite) lockSel_reg <= regWrData[0];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rd_answer;
      regRdEn |=> regRdValid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read strobe got no valid");
   property p_rd_quiet;
      !regRdEn |=> !regRdValid;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("valid without a read");
   property p_reset;
      disable iff (1'b0) rst |=> (!deviceIrq && !lockStatusPin && !regRdValid);
   endproperty
   a_reset: assert property (p_reset) else $error("outputs active after reset");
   property p_irq_gate;
      deviceIrq |-> $past(enShadow_reg[15]);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
   property p_src_gate;
      deviceIrq |-> ($past(enShadow_reg[8:0]) != 9'h000 || $past(enShadow_reg[8:0], 2) != 9'h000);
   endproperty
   a_src_gate: assert property (p_src_gate) else $error("irq with no source enabled");
   property p_pin_lock;
      (!$past(rst) && !$past(lockSel_reg)) |-> lockStatusPin == $past(loopLockStatus);
   endproperty
   a_pin_lock: assert property (p_pin_lock) else $error("pin not showing lock input");
   property p_pin_irq;
      (!$past(rst) && $past(lockSel_reg)) |-> lockStatusPin == deviceIrq;
   endproperty
   a_pin_irq: assert property (p_pin_irq) else $error("pin not showing interrupt");
   property p_unmapped;
      (regRdEn && regAddr == 8'h0F) |=> regRdData == clock_monitor_pkg::READ_UNMAPPED;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_en_read;
      (regRdEn && enWrite == regWrEn && regAddr == clock_monitor_pkg::ADDR_INT_EN)
         |=> regRdData == {16'h0000, $past(enShadow_reg)};
   endproperty
   a_en_read: assert property (p_en_read) else $error("enable readback wrong");
endmodule : clock_monitor_interrupt_unit_asserts
bind clock_monitor_interrupt_unit clock_monitor_interrupt_unit_asserts chk_u (.sys_clk(sys_clk),
   .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
   .regRdData(regRdData), .regRdValid(regRdValid), .loopLockStatus(loopLockStatus),
   .lockStatusPin(lockStatusPin), .deviceIrq(deviceIrq));
`default_nettype wire

// >>> tb/monitor_clock_source.sv
// Purpose: Far-end source of the three monitored clocks.
// Assumes: The bench sets the half period in nanoseconds.
// Notes: A channel that is not running holds its line low, as a stopped oscillator would.
`timescale 1ns/1ns
`default_nettype none
module monitor_clock_source (
   input wire logic [2:0] run,
   input wire logic [31:0] halfNs,
   output logic [2:0] clkOut
);
   logic [2:0] level = 3'h0;
   assign clkOut = level;
   for (genvar i = 0; i < 3; i++) begin : g_ch
      initial begin
         forever begin
            #((halfNs | 32'h0000_0001) + i);
            level[i] = run[i] ? ~level[i] : 1'b0;
         end
      end
   end
endmodule : monitor_clock_source
`default_nettype wire

// >>> tb/clock_monitor_interrupt_unit_bench.sv
// Purpose: Self-checking bench for the clock monitor interrupt unit.
// Assumes: Monitor 0 sees a 1 us clock, then a 2 us clock, then none; the other monitors stay in loss.
// Notes: Expected values come from a small integer model of events and enables.
`timescale 1ns/1ns
`default_nettype none
module clock_monitor_interrupt_unit_bench;
   localparam logic [7:0] AEN = clock_monitor_pkg::ADDR_INT_EN;
   localparam logic [7:0] ST0 = clock_monitor_pkg::ADDR_MON_BASE;
   localparam logic [7:0] EV0 = ST0 + clock_monitor_pkg::OFF_EVENT;
   localparam logic [7:0] WN0 = ST0 + clock_monitor_pkg::OFF_WINDOW;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0000_0000;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [31:0] regRdData;
   logic regRdValid;
   logic [2:0] monClk;
   logic [2:0] run = 3'h0;
   logic [31:0] halfNs = 32'h0000_01F4;
   logic [1:0] actDis = 2'h0;
   logic [1:0] actEvt = 2'h0;
   clock_monitor_pkg::loop_events_t loopEvt = 4'h0;
   logic lockIn = 1'b0;
   logic lockPin;
   logic irq;
   integer seed = 32'h0000_ECF8;
   int miscompares = 0;
   int totalChecks = 0;
   int intEn = 0;
   int losEvt [3] = '{1, 1, 1};
   always #25 sys_clk = ~sys_clk;
   clock_monitor_interrupt_unit dut_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .regRdValid(regRdValid), .monitorClock(monClk), .activityDisqualify(actDis),
      .activityEvent(actEvt), .loopEvents(loopEvt), .loopLockStatus(lockIn),
      .lockStatusPin(lockPin), .deviceIrq(irq));
   monitor_clock_source src_u (.run(run), .halfNs(halfNs), .clkOut(monClk));
   function automatic logic [31:0] expSts();
      int s;
      s = (int'(actEvt) << 7) | (losEvt[2] << 6) | (losEvt[1] << 5) | (losEvt[0] << 4);
      s = s | int'(loopEvt);
      if ((s & intEn & 32'h0000_01FF) != 0) s = s | 32'h0000_8000;
      return 32'(s);
   endfunction : expSts
   task automatic reportAndStop();
      if (miscompares == 0 && totalChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : reportAndStop
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Each access leaves one idle cycle so no strobe is lowered and raised in one step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(posedge sys_clk);
      #5 regWrEn = 1'b0;
      @(posedge sys_clk);
      #5;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      regAddr = a;
      regRdEn = 1'b1;
      @(posedge sys_clk);
      #5 regRdEn = 1'b0;
      for (n = 0; n < 4 && regRdValid !== 1'b1; n++) begin
         @(posedge sys_clk);
         #5;
      end
      if (n == 4) begin
         miscompares++;
         reportAndStop();
      end
      d = regRdData;
      @(posedge sys_clk);
      #5;
   endtask : rd
   task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(what, v, exp);
   endtask : rc
   task automatic waitLoss(input logic want);
      logic [31:0] v;
      int n;
      v = 32'h0000_0000;
      for (n = 0; n < 200; n++) begin
         rd(ST0, v);
         if (v[0] === want) break;
      end
      if (n == 200) begin
         miscompares++;
         reportAndStop();
      end
   endtask : waitLoss
   initial begin
      logic [31:0] raw;
      logic [31:0] exp;
      logic e;
      int lockSel;
      repeat (16) @(posedge sys_clk);
      #5 rst = 1'b0;
      rc("enable reset", AEN, 32'(clock_monitor_pkg::INT_EN_RESET));
      for (int m = 0; m < 3; m++) begin
         rc("status reset", ST0 + 8'(m * 16), 32'h0000_0003);
         rc("event reset", EV0 + 8'(m * 16), 32'h0000_0001);
      end
      rc("int status reset", clock_monitor_pkg::ADDR_INT_STS, expSts());
      rc("unmapped", 8'h0F, clock_monitor_pkg::READ_UNMAPPED);
      wr(EV0, 32'h0000_0000);
      rc("event write 0", EV0, 32'h0000_0001);
      wr(EV0, 32'h0000_0001);
      rc("event write 1 in loss", EV0, 32'h0000_0001);
      wr(clock_monitor_pkg::ADDR_SOFT_RST, 32'h0000_0001);
      wr(ST0 + clock_monitor_pkg::OFF_QUAL, 32'h0000_0000);
      wr(ST0 + clock_monitor_pkg::OFF_THRESH, 32'h0002_0004);
      wr(ST0 + clock_monitor_pkg::OFF_NOMINAL, 32'h0000_0014);
      wr(clock_monitor_pkg::ADDR_SOFT_RST, 32'h0000_0000);
      rc("event after soft reset", EV0, 32'h0000_0001);
      run = 3'h1;
      waitLoss(1'b0);
      rc("qualified", ST0, 32'h0000_0000);
      rc("event held", EV0, 32'h0000_0001);
      wr(EV0, 32'h0000_0001);
      losEvt[0] = 0;
      rc("event cleared", EV0, 32'h0000_0000);
      actDis = 2'h1;
      #100;
      rc("activity invalid", ST0, 32'h0000_0002);
      actDis = 2'h0;
      wr(WN0, 32'h0000_0002);
      rc("disable invalid", ST0, 32'h0000_0002);
      wr(WN0, 32'h0000_0000);
      halfNs = 32'h0000_03E8;
      waitLoss(1'b1);
      losEvt[0] = 1;
      rc("loss seen", ST0, 32'h0000_0003);
      wr(EV0, 32'h0000_0001);
      rc("event kept in loss", EV0, 32'h0000_0001);
      wr(WN0, 32'h0000_0001);
      rc("masked invalid", ST0, 32'h0000_0001);
      // Divide by 2 on a 2 us clock gives 80 counts; two good windows are needed.
      wr(clock_monitor_pkg::ADDR_SOFT_RST, 32'h0000_0001);
      wr(ST0 + clock_monitor_pkg::OFF_QUAL, 32'h0000_0021);
      wr(WN0, 32'h0000_0010);
      wr(ST0 + clock_monitor_pkg::OFF_NOMINAL, 32'h0000_0050);
      wr(clock_monitor_pkg::ADDR_SOFT_RST, 32'h0000_0000);
      waitLoss(1'b0);
      rc("divided qualify", ST0, 32'h0000_0000);
      run = 3'h0;
      waitLoss(1'b1);
      rc("stopped clock loss", ST0, 32'h0000_0003);
      for (int i = 0; i < 16; i++) begin
         raw = $random(seed);
         lockSel = $random(seed) & 1;
         loopEvt = 4'($random(seed));
         actEvt = 2'($random(seed));
         lockIn = 1'($random(seed));
         wr(AEN, raw);
         wr(clock_monitor_pkg::ADDR_LOCK_SEL, 32'(lockSel));
         intEn = raw & 32'h0000_8FFF;
         rc("int enable", AEN, 32'(intEn));
         exp = expSts();
         rc("int status", clock_monitor_pkg::ADDR_INT_STS, exp);
         e = exp[15] & raw[15];
         chk("device irq", {31'h0000_0000, irq}, {31'h0000_0000, e});
         chk("lock pin", {31'h0000_0000, lockPin}, {31'h0000_0000, lockSel ? e : lockIn});
      end
      reportAndStop();
   end
endmodule : clock_monitor_interrupt_unit_bench
`default_nettype wire
